// >>> hdl/dcbfl_top.v
// DC injection brake sequencer and frequency setpoint limiter with AHB-Lite registers
`default_nettype none
`include "dcbfl_defines.vh"

module dcbfl_top #(
    parameter MS_CYCLES = `DCBFL_CLK_HZ / `DCBFL_MS_PER_S,
    parameter FW = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire start_cmd,
    input wire stop_cmd,
    input wire brake_command_input,
    input wire [FW-1:0] actual_freq,
    input wire [FW-1:0] freq_setpoint,
    input wire [FW-1:0] start_freq,
    input wire [FW-1:0] end_freq,
    output reg [FW-1:0] freq_cmd,
    output reg inverter_run,
    output reg dc_injection_brake,
    output reg brake_pulse,
    output reg [6:0] brake_torque
);

    // One-hot sequencer states
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_PRE = 5'h02;
    localparam [4:0] ST_RUN = 5'h04;
    localparam [4:0] ST_COAST = 5'h08;
    localparam [4:0] ST_DEC = 5'h10;

    reg [1:0] auto_en_ff;
    reg [1:0] behav_ff;
    reg set2_ff;
    reg [FW-1:0] act_freq_ff;
    reg [15:0] coast_ms_ff;
    reg [6:0] dec_trq_ff;
    reg [15:0] dec_ms_ff;
    reg [6:0] pre_trq_ff;
    reg [15:0] pre_ms_ff;
    reg [7:0] pulse_ff;
    reg [FW-1:0] upper_ff;
    reg [FW-1:0] lower_ff;
    reg [FW-1:0] upper2_ff;
    reg [FW-1:0] lower2_ff;
    reg [FW-1:0] jc_ff [0:2];
    reg [FW-1:0] jw_ff [0:2];

    reg [4:0] state_ff;
    reg [4:0] nxt_state;
    reg [15:0] ms_cnt_ff;
    reg [31:0] tick_cnt_ff;
    reg first_run_ff;
    reg [21:0] phase_ff;
    reg [2:0] start_sync_ff;
    reg [2:0] stop_sync_ff;
    reg [2:0] brk_sync_ff;
    reg start_ff;
    reg stop_ff;
    reg brk_ff;
    reg start_q_ff;
    reg wr_pend_ff;
    reg [7:0] wr_addr_ff;

    wire ms_tick;
    wire start_rise;
    wire [FW-1:0] upper_sel;
    wire [FW-1:0] lower_sel;
    wire [7:0] pulse_use;
    wire [21:0] phase_sum;
    wire [21:0] duty_lim;
    wire addr_phase;
    integer i;
    // Separate loop index for the combinational band search
    integer k;

    // Bus answers at once, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_phase = hsel & hready & htrans[1];

    // Pin synchronisers: change counts once stages 2 and 3 agree
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_sync_ff <= 3'h0;
            stop_sync_ff <= 3'h0;
            brk_sync_ff <= 3'h0;
            start_ff <= 1'b0;
            stop_ff <= 1'b0;
            brk_ff <= 1'b0;
            start_q_ff <= 1'b0;
        end
        else
        begin
            start_sync_ff <= {start_sync_ff[1:0], start_cmd};
            stop_sync_ff <= {stop_sync_ff[1:0], stop_cmd};
            brk_sync_ff <= {brk_sync_ff[1:0], brake_command_input};
            if (start_sync_ff[1] == start_sync_ff[2])
                start_ff <= start_sync_ff[2];
            if (stop_sync_ff[1] == stop_sync_ff[2])
                stop_ff <= stop_sync_ff[2];
            if (brk_sync_ff[1] == brk_sync_ff[2])
                brk_ff <= brk_sync_ff[2];
            start_q_ff <= start_ff;
        end
    end

    assign start_rise = start_ff & ~start_q_ff;

    // Register writes in the data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            auto_en_ff <= `DCBFL_RST_AUTO;
            behav_ff <= `DCBFL_RST_BEHAV;
            set2_ff <= 1'b0;
            act_freq_ff <= `DCBFL_RST_ACT_FREQ;
            coast_ms_ff <= 16'h0000;
            dec_trq_ff <= 7'h00;
            dec_ms_ff <= 16'h0000;
            pre_trq_ff <= 7'h00;
            pre_ms_ff <= 16'h0000;
            pulse_ff <= `DCBFL_RST_PULSE;
            upper_ff <= {FW{1'b0}};
            lower_ff <= {FW{1'b0}};
            upper2_ff <= {FW{1'b0}};
            lower2_ff <= {FW{1'b0}};
            for (i = 0; i < 3; i = i + 1)
            begin
                jc_ff[i] <= {FW{1'b0}};
                jw_ff[i] <= `DCBFL_RST_JUMP_W;
            end
        end
        else
        begin
            wr_pend_ff <= addr_phase & hwrite;
            wr_addr_ff <= haddr;
            if (wr_pend_ff)
            begin
                if (wr_addr_ff == `DCBFL_ADDR_CTRL)
                begin
                    auto_en_ff <= hwdata[`DCBFL_CTRL_AUTO];
                    behav_ff <= hwdata[`DCBFL_CTRL_BEHAV];
                    set2_ff <= hwdata[`DCBFL_CTRL_SET2];
                end
                else if (wr_addr_ff == `DCBFL_ADDR_ACT_FREQ)
                    act_freq_ff <= hwdata[FW-1:0];
                else if (wr_addr_ff == `DCBFL_ADDR_COAST)
                    coast_ms_ff <= hwdata[15:0];
                else if (wr_addr_ff == `DCBFL_ADDR_DEC_TRQ)
                    dec_trq_ff <= sat_trq(hwdata[7:0]);
                else if (wr_addr_ff == `DCBFL_ADDR_DEC_DUR)
                    dec_ms_ff <= hwdata[15:0];
                else if (wr_addr_ff == `DCBFL_ADDR_PRE_TRQ)
                    pre_trq_ff <= sat_trq(hwdata[7:0]);
                else if (wr_addr_ff == `DCBFL_ADDR_PRE_DUR)
                    pre_ms_ff <= hwdata[15:0];
                else if (wr_addr_ff == `DCBFL_ADDR_PULSE)
                    pulse_ff <= hwdata[7:0];
                else if (wr_addr_ff == `DCBFL_ADDR_UPPER)
                    upper_ff <= hwdata[FW-1:0];
                else if (wr_addr_ff == `DCBFL_ADDR_LOWER)
                    lower_ff <= hwdata[FW-1:0];
                else if (wr_addr_ff == `DCBFL_ADDR_UPPER2)
                    upper2_ff <= hwdata[FW-1:0];
                else if (wr_addr_ff == `DCBFL_ADDR_LOWER2)
                    lower2_ff <= hwdata[FW-1:0];
                else if (wr_addr_ff[7:2] >= `DCBFL_ADDR_JUMP0 >> 2 && wr_addr_ff[7:2] < (`DCBFL_ADDR_JUMP0 >> 2) + 6)
                begin
                    for (i = 0; i < 3; i = i + 1)
                    begin
                        if (wr_addr_ff == `DCBFL_ADDR_JUMP0 + 8 * i)
                            jc_ff[i] <= hwdata[FW-1:0];
                        if (wr_addr_ff == `DCBFL_ADDR_JUMP0 + 8 * i + 4)
                            jw_ff[i] <= hwdata[FW-1:0];
                    end
                end
            end
        end
    end

    // Torque percentage saturates at full torque
    function [6:0] sat_trq;
        input [7:0] v;
        begin
            sat_trq = (v > {1'b0, `DCBFL_TRQ_MAX}) ? `DCBFL_TRQ_MAX : v[6:0];
        end
    endfunction

    // Read data registered in the address phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (addr_phase && !hwrite)
        begin
            if (haddr == `DCBFL_ADDR_CTRL)
                hrdata <= {27'h0, set2_ff, behav_ff, auto_en_ff};
            else if (haddr == `DCBFL_ADDR_ACT_FREQ)
                hrdata <= {16'h0, act_freq_ff};
            else if (haddr == `DCBFL_ADDR_COAST)
                hrdata <= {16'h0, coast_ms_ff};
            else if (haddr == `DCBFL_ADDR_DEC_TRQ)
                hrdata <= {25'h0, dec_trq_ff};
            else if (haddr == `DCBFL_ADDR_DEC_DUR)
                hrdata <= {16'h0, dec_ms_ff};
            else if (haddr == `DCBFL_ADDR_PRE_TRQ)
                hrdata <= {25'h0, pre_trq_ff};
            else if (haddr == `DCBFL_ADDR_PRE_DUR)
                hrdata <= {16'h0, pre_ms_ff};
            else if (haddr == `DCBFL_ADDR_PULSE)
                hrdata <= {24'h0, pulse_ff};
            else if (haddr == `DCBFL_ADDR_UPPER)
                hrdata <= {16'h0, upper_ff};
            else if (haddr == `DCBFL_ADDR_LOWER)
                hrdata <= {16'h0, lower_ff};
            else if (haddr == `DCBFL_ADDR_UPPER2)
                hrdata <= {16'h0, upper2_ff};
            else if (haddr == `DCBFL_ADDR_LOWER2)
                hrdata <= {16'h0, lower2_ff};
            else if (haddr == `DCBFL_ADDR_STATUS)
                hrdata <= {brk_ff, 7'h0, 3'h0, state_ff, freq_cmd};
            else if (haddr == `DCBFL_ADDR_JUMP0)
                hrdata <= {16'h0, jc_ff[0]};
            else if (haddr == `DCBFL_ADDR_JUMP0 + 8'h04)
                hrdata <= {16'h0, jw_ff[0]};
            else if (haddr == `DCBFL_ADDR_JUMP0 + 8'h08)
                hrdata <= {16'h0, jc_ff[1]};
            else if (haddr == `DCBFL_ADDR_JUMP0 + 8'h0c)
                hrdata <= {16'h0, jw_ff[1]};
            else if (haddr == `DCBFL_ADDR_JUMP0 + 8'h10)
                hrdata <= {16'h0, jc_ff[2]};
            else if (haddr == `DCBFL_ADDR_JUMP0 + 8'h14)
                hrdata <= {16'h0, jw_ff[2]};
            else
                hrdata <= 32'h00000000;
        end
    end

    // Millisecond tick for coast and braking timers
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tick_cnt_ff <= 32'h00000000;
        else if (tick_cnt_ff >= MS_CYCLES - 1)
            tick_cnt_ff <= 32'h00000000;
        else
            tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
    end

    assign ms_tick = (tick_cnt_ff >= MS_CYCLES - 1);

    // Braking sequencer next state
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (start_rise)
                    nxt_state = (pre_trq_ff == 7'h00 || pre_ms_ff == 16'h0000) ? ST_RUN : ST_PRE;
            end
            ST_PRE:
            begin
                if (ms_cnt_ff >= pre_ms_ff)
                    nxt_state = ST_RUN;
            end
            ST_RUN:
            begin
                if (stop_ff && brk_ff)
                    nxt_state = ST_COAST;
                else if (stop_ff && auto_en_ff == `DCBFL_CODE_01 && actual_freq < act_freq_ff)
                    nxt_state = ST_COAST;
                else if (stop_ff && actual_freq == {FW{1'b0}})
                    nxt_state = ST_IDLE;
            end
            ST_COAST:
            begin
                if (behav_ff == `DCBFL_CODE_01 && !brk_ff && auto_en_ff != `DCBFL_CODE_01)
                    nxt_state = ST_IDLE;
                else if (ms_cnt_ff >= coast_ms_ff)
                begin
                    if (dec_trq_ff == 7'h00)
                        nxt_state = ST_IDLE;
                    else if (behav_ff == `DCBFL_CODE_01 && brk_ff)
                        nxt_state = ST_DEC;
                    else if (dec_ms_ff == 16'h0000)
                        nxt_state = ST_IDLE;
                    else
                        nxt_state = ST_DEC;
                end
            end
            ST_DEC:
            begin
                if (behav_ff == `DCBFL_CODE_01 && !brk_ff && auto_en_ff != `DCBFL_CODE_01)
                    nxt_state = ST_IDLE;
                else if (behav_ff == `DCBFL_CODE_01 && brk_ff)
                    nxt_state = ST_DEC;
                else if (ms_cnt_ff >= dec_ms_ff)
                    nxt_state = ST_IDLE;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // State and millisecond timer, timer restarts on every state change
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff <= ST_IDLE;
            ms_cnt_ff <= 16'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            if (nxt_state != state_ff)
                ms_cnt_ff <= 16'h0000;
            else if (ms_tick && ms_cnt_ff != 16'hffff)
                ms_cnt_ff <= ms_cnt_ff + 16'h0001;
        end
    end

    // Braking pulse generator, phase accumulator at its own frequency
    assign pulse_use = (pulse_ff < `DCBFL_PULSE_MIN) ? `DCBFL_PULSE_MIN :
                       (pulse_ff > `DCBFL_PULSE_MAX) ? `DCBFL_PULSE_MAX : pulse_ff;
    assign phase_sum = phase_ff + {14'h0, pulse_use};
    assign duty_lim = brake_torque * `DCBFL_PHASE_PER_PCT;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_ff <= 22'h000000;
            brake_pulse <= 1'b0;
            brake_torque <= 7'h00;
            dc_injection_brake <= 1'b0;
            inverter_run <= 1'b0;
        end
        else
        begin
            phase_ff <= (phase_sum >= `DCBFL_PHASE_MOD) ? phase_sum - `DCBFL_PHASE_MOD : phase_sum;
            brake_torque <= (state_ff == ST_PRE) ? pre_trq_ff : (state_ff == ST_DEC) ? dec_trq_ff : 7'h00;
            dc_injection_brake <= (state_ff == ST_PRE) || (state_ff == ST_DEC);
            brake_pulse <= ((state_ff == ST_PRE) || (state_ff == ST_DEC)) && (phase_ff < duty_lim);
            inverter_run <= (state_ff == ST_RUN);
        end
    end

    // Setpoint clamp and jump bands
    assign upper_sel = set2_ff ? upper2_ff : upper_ff;
    assign lower_sel = set2_ff ? lower2_ff : lower_ff;

    function [FW-1:0] clamp;
        input [FW-1:0] v;
        input [FW-1:0] lo;
        input [FW-1:0] hi;
        begin
            clamp = (v < lo) ? lo : (v > hi) ? hi : v;
        end
    endfunction

    reg [FW-1:0] nxt_freq;
    reg [FW:0] band_lo;
    reg [FW:0] band_hi;

    always @*
    begin
        nxt_freq = clamp(freq_setpoint, start_freq, end_freq);
        if (nxt_freq < lower_sel)
            nxt_freq = lower_sel;
        if (upper_sel != {FW{1'b0}} && nxt_freq > upper_sel)
            nxt_freq = upper_sel;
        band_lo = {(FW+1){1'b0}};
        band_hi = {(FW+1){1'b0}};
        for (k = 0; k < 3; k = k + 1)
        begin
            band_lo = (jc_ff[k] > jw_ff[k]) ? {1'b0, jc_ff[k] - jw_ff[k]} : {(FW+1){1'b0}};
            band_hi = {1'b0, jc_ff[k]} + {1'b0, jw_ff[k]};
            if (jw_ff[k] != {FW{1'b0}} && {1'b0, nxt_freq} > band_lo && {1'b0, nxt_freq} < band_hi)
                nxt_freq = (nxt_freq >= freq_cmd) ? band_lo[FW-1:0] : band_hi[FW-1:0];
        end
    end

    // Frequency command register
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            freq_cmd <= {FW{1'b0}};
            first_run_ff <= 1'b0;
        end
        else
        begin
            first_run_ff <= (nxt_state == ST_RUN) && (state_ff != ST_RUN);
            if (state_ff != ST_RUN)
                freq_cmd <= {FW{1'b0}};
            else if (first_run_ff)
                freq_cmd <= lower_sel;
            else if (stop_ff)
                freq_cmd <= {FW{1'b0}};
            else
                freq_cmd <= nxt_freq;
        end
    end

endmodule
`default_nettype wire

// >>> hdl/dcbfl_defines.vh
// Constants for DC braking sequencer and frequency limiter
// What this block does
// - Auto braking code 00 disables, 01 enables frequency-triggered braking; default 00
// - Auto braking starts once actual frequency drops below threshold, 0-60 Hz, default 0.50
// - Deceleration braking applies DC at programmable torque 0-100 %
// - Deceleration braking lasts programmable 0-60 s, default zero
// - Brake input code 00: braking runs full programmed duration regardless of input
// - Brake input code 01, default: braking active while input asserted; with auto code 01, release leaves braking to its timed duration
// - Braking torque comes from pulsed DC voltage applied to the stator
// - Optional pre-start DC braking on start with torque 0-100 %
// - Pre-start braking lasts programmable 0-60 s before acceleration
// - Braking has own pulse frequency 0.5-15 or 0.5-10 kHz, default 3.0
// - Operating frequency clamped between start/end frequency by upper and lower limits
// - Upper limit 0-400 Hz; value zero disables upper limiting
// - On start the minimum operating frequency is output immediately
// - Three jump frequencies 0-400 Hz, each width 0-10 Hz, default 0.5
`ifndef DCBFL_DEFINES_VH
`define DCBFL_DEFINES_VH

// Clock and time base
`define DCBFL_CLK_HZ 250000000
`define DCBFL_MS_PER_S 1000
// Phase modulus: clock rate over 100 Hz pulse-frequency unit
`define DCBFL_PHASE_MOD 22'd2500000
`define DCBFL_PHASE_PER_PCT 22'd25000
`define DCBFL_PULSE_MIN 8'h05
`define DCBFL_PULSE_MAX 8'h96

// Register byte offsets
`define DCBFL_ADDR_CTRL 8'h00
`define DCBFL_ADDR_ACT_FREQ 8'h04
`define DCBFL_ADDR_COAST 8'h08
`define DCBFL_ADDR_DEC_TRQ 8'h0c
`define DCBFL_ADDR_DEC_DUR 8'h10
`define DCBFL_ADDR_PRE_TRQ 8'h14
`define DCBFL_ADDR_PRE_DUR 8'h18
`define DCBFL_ADDR_PULSE 8'h1c
`define DCBFL_ADDR_UPPER 8'h20
`define DCBFL_ADDR_LOWER 8'h24
`define DCBFL_ADDR_UPPER2 8'h28
`define DCBFL_ADDR_LOWER2 8'h2c
`define DCBFL_ADDR_JUMP0 8'h30
`define DCBFL_ADDR_STATUS 8'h48

// Control register fields
`define DCBFL_CTRL_AUTO 1:0
`define DCBFL_CTRL_BEHAV 3:2
`define DCBFL_CTRL_SET2 4

// Codes and reset values
`define DCBFL_CODE_00 2'h0
`define DCBFL_CODE_01 2'h1
`define DCBFL_RST_AUTO 2'h0
`define DCBFL_RST_BEHAV 2'h1
`define DCBFL_RST_ACT_FREQ 16'h0032
`define DCBFL_RST_PULSE 8'h1e
`define DCBFL_RST_JUMP_W 16'h0032
`define DCBFL_TRQ_MAX 7'h64

`endif

// >>> tb/dcbfl_props.sv
// Port-level assertion checker for the brake sequencer and limiter
`default_nettype none
module dcbfl_props #(
    parameter MS_CYCLES = 10,
    parameter FW = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire inverter_run,
    input wire dc_injection_brake,
    input wire brake_pulse,
    input wire [6:0] brake_torque
);
    timeunit 1ns;
    timeprecision 1ps;
    // Read request taken on this edge
    wire rd_take = hsel && hready && htrans[1] && !hwrite;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_ready_high: assert property (hreadyout) else $error("slave inserted a wait state");
    a_resp_okay: assert property (!hresp) else $error("slave answered with an error");
    a_rdata_hold: assert property (!$past(rd_take) |-> $stable(hrdata)) else $error("read data moved without a read");
    a_pulse_gate: assert property (!dc_injection_brake |-> !brake_pulse) else $error("pulse outside brake");
    a_torque_idle: assert property (!dc_injection_brake |-> brake_torque == 7'h00) else $error("torque while idle");
    a_torque_range: assert property (brake_torque <= 7'h64) else $error("torque above full scale");
    a_torque_live: assert property (dc_injection_brake |-> brake_torque != 7'h00) else $error("brake at zero torque");
    a_run_excl: assert property (!(inverter_run && dc_injection_brake)) else $error("run and brake together");
    a_coast_first: assert property ($rose(dc_injection_brake) |-> !$past(inverter_run)) else $error("brake without coast");
endmodule
bind dcbfl_top dcbfl_props #(.MS_CYCLES(MS_CYCLES), .FW(FW)) i_dcbfl_props (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .inverter_run(inverter_run), .dc_injection_brake(dc_injection_brake),
    .brake_pulse(brake_pulse), .brake_torque(brake_torque));
`default_nettype wire

// >>> tb/dcbfl_stator_model.sv
// Behavioural motor stator that turns drive outputs into a speed reading
`default_nettype none
module dcbfl_stator_model #(
    parameter FW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inverter_run,
    input wire logic dc_injection_brake,
    input wire logic brake_pulse,
    input wire logic [FW-1:0] freq_cmd,
    output var logic [FW-1:0] actual_freq
);
    timeunit 1ns;
    timeprecision 1ps;
    // Speed follows drive, falls fast under DC pulses, slowly when coasting
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            actual_freq <= '0;
        else if (inverter_run)
            actual_freq <= freq_cmd;
        else if (dc_injection_brake && brake_pulse)
            actual_freq <= (actual_freq > 200) ? actual_freq - 200 : '0;
        else if (actual_freq != 0)
            actual_freq <= actual_freq - 1;
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the brake sequencer and frequency limiter
`default_nettype none
`include "dcbfl_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 10;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic start_cmd = 1'b0, stop_cmd = 1'b0, brk_in = 1'b0;
    logic [15:0] freq_setpoint = 16'h0, start_freq = 16'h0, end_freq = 16'd40000;
    wire hreadyout, hresp, inverter_run, dc_injection_brake, brake_pulse;
    wire [31:0] hrdata;
    wire [15:0] freq_cmd, actual_freq;
    wire [6:0] brake_torque;
    int bad_count = 0;
    int checks_done = 0;
    int n;
    logic [31:0] rd;
    always #2 hclk = ~hclk;
    dcbfl_top #(.MS_CYCLES(MSC)) i_dcbfl_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
        .brake_command_input(brk_in), .actual_freq(actual_freq), .freq_setpoint(freq_setpoint),
        .start_freq(start_freq), .end_freq(end_freq), .freq_cmd(freq_cmd), .inverter_run(inverter_run),
        .dc_injection_brake(dc_injection_brake), .brake_pulse(brake_pulse), .brake_torque(brake_torque));
    dcbfl_stator_model i_dcbfl_stator_model (.clk(hclk), .rst_n(hresetn), .inverter_run(inverter_run),
        .dc_injection_brake(dc_injection_brake), .brake_pulse(brake_pulse), .freq_cmd(freq_cmd),
        .actual_freq(actual_freq));
    // Verdict and end of run
    task end_of_test;
        $display("mismatches %0d, checks %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Compare and report
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single AHB-Lite word transfer
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask
    // Count edges until run (sel 1) or brake (sel 0) reaches a level
    task wait_for(input int sel, input logic lvl, input int lim);
        n = 0;
        while ((sel == 1 ? inverter_run : dc_injection_brake) !== lvl && n < lim)
        begin
            @(posedge hclk);
            n++;
        end
    endtask
    // New setpoint, then look at the command
    task fset(input logic [15:0] sp, input logic [15:0] exp);
        @(posedge hclk);
        freq_setpoint <= sp;
        repeat (4) @(posedge hclk);
        check(freq_cmd, exp);
    endtask
    // Reset values, saturation, unmapped space
    task s_regs;
        bus(1'b0, `DCBFL_ADDR_CTRL, 32'h0);
        check(rd, 32'h4);
        bus(1'b0, `DCBFL_ADDR_ACT_FREQ, 32'h0);
        check(rd, 32'h32);
        bus(1'b0, `DCBFL_ADDR_PULSE, 32'h0);
        check(rd, 32'h1e);
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b0, `DCBFL_ADDR_JUMP0 + 8'h04 + 8'(8 * i), 32'h0);
            check(rd, 32'h32);
        end
        bus(1'b0, 8'h4c, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, `DCBFL_ADDR_DEC_TRQ, 32'hc8);
        bus(1'b0, `DCBFL_ADDR_DEC_TRQ, 32'h0);
        check(rd, 32'h64);
    endtask
    // Pre-start brake then run at the lower limit
    task s_prestart;
        bus(1'b1, `DCBFL_ADDR_PRE_TRQ, 32'd50);
        bus(1'b1, `DCBFL_ADDR_PRE_DUR, 32'd3);
        bus(1'b1, `DCBFL_ADDR_LOWER, 32'd1000);
        @(posedge hclk);
        start_cmd <= 1'b1;
        wait_for(0, 1'b1, 20);
        check(n < 20, 1'b1);
        repeat (3) @(posedge hclk);
        check(brake_torque, 32'd50);
        wait_for(0, 1'b0, 60);
        check(n + 3 >= 3 * MSC - 2 && n + 3 <= 3 * MSC + 3, 1'b1);
        wait_for(1, 1'b1, 5);
        check(n < 5, 1'b1);
        repeat (3) @(posedge hclk);
        check(freq_cmd, 32'd1000);
    endtask
    // Upper, lower and end clamps and the three jump bands
    task s_limits;
        bus(1'b1, `DCBFL_ADDR_UPPER, 32'd4000);
        fset(16'd5000, 16'd4000);
        bus(1'b1, `DCBFL_ADDR_UPPER, 32'd0);
        fset(16'd5000, 16'd5000);
        fset(16'd45000, 16'd40000);
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, `DCBFL_ADDR_JUMP0 + 8'(8 * i), 32'd2000 + 32'd1000 * i);
            bus(1'b1, `DCBFL_ADDR_JUMP0 + 8'h04 + 8'(8 * i), 32'd100);
            fset(16'd500, 16'd1000);
            fset(16'd2030 + 16'd1000 * i, 16'd1900 + 16'd1000 * i);
        end
        bus(1'b1, `DCBFL_ADDR_UPPER2, 32'd3500);
        bus(1'b1, `DCBFL_ADDR_CTRL, 32'h14);
        fset(16'd5000, 16'd3500);
        bus(1'b1, `DCBFL_ADDR_CTRL, 32'h4);
        start_freq <= 16'd1500;
        fset(16'd500, 16'd1500);
        @(posedge hclk);
        start_freq <= 16'd0;
        fset(16'd5000, 16'd5000);
        fset(16'd1970, 16'd2100);
    endtask
    // Brake held by the input, ends on release
    task s_brake_level;
        bus(1'b1, `DCBFL_ADDR_COAST, 32'd2);
        bus(1'b1, `DCBFL_ADDR_DEC_TRQ, 32'd30);
        bus(1'b1, `DCBFL_ADDR_DEC_DUR, 32'd5);
        @(posedge hclk);
        stop_cmd <= 1'b1;
        brk_in <= 1'b1;
        start_cmd <= 1'b0;
        wait_for(1, 1'b0, 20);
        check(n < 20, 1'b1);
        wait_for(0, 1'b1, 40);
        check(n >= 2 * MSC - 2 && n <= 2 * MSC + 3, 1'b1);
        repeat (2) @(posedge hclk);
        check(brake_torque, 32'd30);
        check(brake_pulse, 1'b1);
        repeat (100) @(posedge hclk);
        check(dc_injection_brake, 1'b1);
        brk_in <= 1'b0;
        wait_for(0, 1'b0, 12);
        check(n < 12, 1'b1);
    endtask
    // Zero pre-start duration, then timed brake despite early release
    task s_timed;
        bus(1'b1, `DCBFL_ADDR_CTRL, 32'h0);
        bus(1'b1, `DCBFL_ADDR_PRE_DUR, 32'd0);
        @(posedge hclk);
        stop_cmd <= 1'b0;
        start_cmd <= 1'b1;
        wait_for(1, 1'b1, 20);
        check(n < 12, 1'b1);
        @(posedge hclk);
        stop_cmd <= 1'b1;
        brk_in <= 1'b1;
        start_cmd <= 1'b0;
        wait_for(0, 1'b1, 60);
        @(posedge hclk);
        brk_in <= 1'b0;
        wait_for(0, 1'b0, 80);
        check(n + 1 >= 5 * MSC - 2 && n + 1 <= 5 * MSC + 2, 1'b1);
    endtask
    // Frequency-triggered brake only once enabled
    task s_auto;
        bus(1'b1, `DCBFL_ADDR_LOWER, 32'd0);
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, `DCBFL_ADDR_CTRL, 32'(k));
            @(posedge hclk);
            stop_cmd <= 1'b0;
            start_cmd <= 1'b1;
            freq_setpoint <= 16'd20;
            wait_for(1, 1'b1, 20);
            repeat (4) @(posedge hclk);
            check(freq_cmd, 32'd20);
            stop_cmd <= 1'b1;
            start_cmd <= 1'b0;
            wait_for(1, 1'b0, 20);
            check(n < 20, 1'b1);
            wait_for(0, 1'b1, 40);
            check(n < 40, k == 1);
        end
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        s_regs;
        s_prestart;
        s_limits;
        s_brake_level;
        s_timed;
        s_auto;
        end_of_test;
    end
    // Hang guard
    initial
    begin
        repeat (40000) @(posedge hclk);
        bad_count++;
        end_of_test;
    end
endmodule
`default_nettype wire
